// [cpu_bus_model.sv]
// Processor side model: a classic Wishbone master for register access.
`timescale 1ns/1ps
module cpu_bus_model (
  input  wire logic        clk,
  input  wire logic        ack,
  input  wire logic [31:0] rdat,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      wdat
);
  initial begin
    cyc  = 1'b0;
    stb  = 1'b0;
    we   = 1'b0;
    adr  = 8'h00;
    sel  = 4'h0;
    wdat = 32'h0;
  end

  // Released we, adr and wdat carry the inverse so a stale value is never mistaken; sel stays 4'hF.
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hF;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q    = rdat;
    cyc  <= 1'b0;
    stb  <= 1'b0;
    we   <= ~w;
    adr  <= ~a;
    wdat <= ~d;
  endtask : access

  task automatic write_word(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    access(1'b1, a, d, q);
  endtask : write_word

  task automatic read_word(input logic [7:0] a, output logic [31:0] q);
    access(1'b0, a, 32'h0, q);
  endtask : read_word
endmodule : cpu_bus_model

// [quad_timer.sv]
// Quad timer and watchdog with a classic Wishbone register slave.
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "quad_timer_defines.svh"
module quad_timer
  import quad_timer_pkg::*;
#(
  parameter int T12_DIV = `CLK_HZ / (`SLOW_OSC_HZ / `T12_OSC_DIV),
  parameter int WD_DIV  = (`CLK_HZ / `SLOW_OSC_HZ) * `WD_OSC_DIV
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             timer_out,
  output logic             irq,
  output logic             nmi,
  output logic             sys_reset_req
);
  localparam int CW = 16;

  logic [31:0] dat_ff;
  logic        ack_ff;
  logic        tout_ff;
  logic        irq_ff;
  logic        wd_rst_ff;
  logic [CW-1:0] t12_div_ff;
  logic [CW-1:0] wd_div_ff;
  logic        t12_tick;
  logic        wd_tick;
  logic [8:0]  ctrl_ff;
  logic [4:0]  status_ff;
  logic [4:0]  mask_ff;
  logic [`T12_W-1:0] match12_ff [2];
  logic [`T32_W-1:0] match32_ff [2];
  logic [`T12_W-1:0] count12 [2];
  logic [`T32_W-1:0] count32 [2];
  logic [3:0]  hit;
  logic [3:0]  running;
  logic [3:0]  start;
  logic [3:0]  stop;
  logic [1:0]  tick12;
  wd_state_type wd_state_ff;
  logic [`WD_W-1:0] wd_cnt_ff;
  logic [`WD_W-1:0] wd_load_ff;
  logic [`WD_W-1:0] wd_warn_ff;
  logic [`WD_W-1:0] nxt_wd_cnt;
  logic        wd_warn_ev;
  logic        wd_expire;
  logic        req;
  logic        wr;
  logic [31:0] wmask;

  // Byte lane mask of a Wishbone write.
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lane_mask

  // Merges written lanes into a stored word.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // Bus requests are taken one cycle before ack, writes on the ack edge.
  assign req   = wb_cyc_i && wb_stb_i;
  assign wr    = req && wb_we_i && ack_ff;
  assign wmask = lane_mask(wb_sel_i);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req && !ack_ff;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dat_ff <= '0;
    end else if (req && !ack_ff) begin
      dat_ff <= '0;
      unique case (wb_adr_i)
        `ADDR_CTRL:     dat_ff <= {23'h0, ctrl_ff[8], ctrl_ff[7:4], running};
        `ADDR_STATUS:   dat_ff <= {27'h0, status_ff};
        `ADDR_MASK:     dat_ff <= {27'h0, mask_ff};
        `ADDR_WD_CTRL:  dat_ff <= {31'h0, wd_state_ff == WD_RUN};
        `ADDR_WD_LOAD:  dat_ff <= {22'h0, wd_load_ff};
        `ADDR_WD_WARN:  dat_ff <= {22'h0, wd_warn_ff};
        `ADDR_WD_COUNT: dat_ff <= {22'h0, wd_cnt_ff};
        `ADDR_MATCH0:      dat_ff <= {20'h0, match12_ff[0]};
        `ADDR_MATCH0 + 4:  dat_ff <= {20'h0, match12_ff[1]};
        `ADDR_MATCH0 + 8:  dat_ff <= match32_ff[0];
        `ADDR_MATCH0 + 12: dat_ff <= match32_ff[1];
        `ADDR_COUNT0:      dat_ff <= {20'h0, count12[0]};
        `ADDR_COUNT0 + 4:  dat_ff <= {20'h0, count12[1]};
        `ADDR_COUNT0 + 8:  dat_ff <= count32[0];
        `ADDR_COUNT0 + 12: dat_ff <= count32[1];
        default:           dat_ff <= '0;
      endcase
    end
  end

  // Slow ticks are one-cycle enables; the 12-bit rate is 182.5 kHz.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      t12_div_ff <= '0;
    end else if (t12_tick) begin
      t12_div_ff <= '0;
    end else begin
      t12_div_ff <= t12_div_ff + 1'b1;
    end
  end
  assign t12_tick = (t12_div_ff == CW'(T12_DIV - 1));

  // The watchdog divider is held at zero while idle, so the first tick
  // after enabling comes one full watchdog period later.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_div_ff <= '0;
    end else if (wd_tick || wd_state_ff == WD_OFF) begin
      wd_div_ff <= '0;
    end else begin
      wd_div_ff <= wd_div_ff + 1'b1;
    end
  end
  assign wd_tick = (wd_div_ff == CW'(WD_DIV - 1));

  // Control: run bits start or stop a timer on write, mode and chain stay.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= '0;
    end else if (wr && wb_adr_i == `ADDR_CTRL) begin
      ctrl_ff <= 9'(merge({23'h0, ctrl_ff}, wb_dat_i, wmask));
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      start[i] = wr && wb_adr_i == `ADDR_CTRL && wmask[i]
                 && wb_dat_i[`CTRL_RUN_LSB + i];
      stop[i]  = wr && wb_adr_i == `ADDR_CTRL && wmask[i]
                 && !wb_dat_i[`CTRL_RUN_LSB + i];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      match12_ff[0] <= '0;
      match12_ff[1] <= '0;
      match32_ff[0] <= '0;
      match32_ff[1] <= '0;
    end else if (wr) begin
      for (int i = 0; i < 2; i++) begin
        if (wb_adr_i == 8'(`ADDR_MATCH0 + 4 * i)) begin
          match12_ff[i] <= `T12_W'(merge({20'h0, match12_ff[i]},
                                          wb_dat_i, wmask));
        end
        if (wb_adr_i == 8'(`ADDR_MATCH0 + 8 + 4 * i)) begin
          match32_ff[i] <= merge(match32_ff[i], wb_dat_i, wmask);
        end
      end
    end
  end

  // Timer 1 steps on timer 0 matches when chained.
  assign tick12[0] = t12_tick;
  assign tick12[1] = ctrl_ff[`CTRL_CHAIN_BIT] ? hit[0] : t12_tick;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_t12
      timer_chan #(.W(`T12_W)) u_chan (
        .clk        (clk),
        .arst_n     (arst_n),
        .tick       (tick12[g]),
        .start      (start[g]),
        .stop       (stop[g]),
        .free_run   (ctrl_ff[`CTRL_FREE_LSB + g]),
        .match      (match12_ff[g]),
        .count_ff   (count12[g]),
        .hit_ff     (hit[g]),
        .running_ff (running[g])
      );
    end
    for (g = 0; g < 2; g++) begin : g_t32
      timer_chan #(.W(`T32_W)) u_chan (
        .clk        (clk),
        .arst_n     (arst_n),
        .tick       (1'b1),
        .start      (start[g + 2]),
        .stop       (stop[g + 2]),
        .free_run   (ctrl_ff[`CTRL_FREE_LSB + g + 2]),
        .match      (match32_ff[g]),
        .count_ff   (count32[g]),
        .hit_ff     (hit[g + 2]),
        .running_ff (running[g + 2])
      );
    end
  endgenerate

  // Sticky status; a new event wins over a write-one clear.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_ff <= '0;
    end else begin
      status_ff <= (status_ff & ~((wr && wb_adr_i == `ADDR_STATUS)
                                  ? wb_dat_i[4:0] & wmask[4:0] : 5'h00))
                   | {wd_warn_ev, hit};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_ff <= '0;
    end else if (wr && wb_adr_i == `ADDR_MASK) begin
      mask_ff <= 5'(merge({27'h0, mask_ff}, wb_dat_i, wmask));
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_ff  <= 1'b0;
      tout_ff <= 1'b0;
    end else begin
      irq_ff  <= |(status_ff[3:0] & mask_ff[3:0]);
      tout_ff <= |hit;
    end
  end

  // Watchdog: counts down from the load value; once on, software only feeds.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_load_ff <= `WD_LOAD_RST;
      wd_warn_ff <= `WD_WARN_RST;
    end else if (wr) begin
      if (wb_adr_i == `ADDR_WD_LOAD) begin
        wd_load_ff <= `WD_W'(merge({22'h0, wd_load_ff}, wb_dat_i, wmask));
      end
      if (wb_adr_i == `ADDR_WD_WARN) begin
        wd_warn_ff <= `WD_W'(merge({22'h0, wd_warn_ff}, wb_dat_i, wmask));
      end
    end
  end

  assign nxt_wd_cnt = wd_cnt_ff - 1'b1;
  assign wd_expire  = wd_state_ff == WD_RUN && wd_tick && wd_cnt_ff == '0;
  assign wd_warn_ev = wd_state_ff == WD_RUN && wd_tick && wd_cnt_ff != '0
                      && nxt_wd_cnt == wd_warn_ff
                      && !(wr && wb_adr_i == `ADDR_WD_FEED);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_state_ff <= WD_OFF;
    end else begin
      unique case (wd_state_ff)
        WD_OFF: if (wr && wb_adr_i == `ADDR_WD_CTRL && wb_dat_i[0]
                    && wmask[0]) begin
          wd_state_ff <= WD_RUN;
        end
        WD_RUN: if (wd_expire && !(wr && wb_adr_i == `ADDR_WD_FEED)) begin
          wd_state_ff <= WD_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_cnt_ff <= '0;
    end else if (wd_state_ff == WD_OFF) begin
      wd_cnt_ff <= wd_load_ff;
    end else if (wr && wb_adr_i == `ADDR_WD_FEED) begin
      wd_cnt_ff <= wd_load_ff;
    end else if (wd_tick && wd_cnt_ff != '0) begin
      wd_cnt_ff <= nxt_wd_cnt;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_rst_ff <= 1'b0;
    end else begin
      wd_rst_ff <= wd_expire && !(wr && wb_adr_i == `ADDR_WD_FEED);
    end
  end

  assign wb_dat_o      = dat_ff;
  assign wb_ack_o      = ack_ff;
  assign timer_out     = tout_ff;
  assign irq           = irq_ff;
  assign nmi           = status_ff[`ST_WD_BIT];
  assign sys_reset_req = wd_rst_ff;

  ack_one_a: assert property (@(posedge clk) disable iff (!arst_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_late_a: assert property (@(posedge clk) disable iff (!arst_n)
    req && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged on the next edge");
  wd_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
    wd_state_ff == WD_OFF |=> !sys_reset_req)
    else $error("reset request from an idle watchdog");
  wd_bite_a: assert property (@(posedge clk) disable iff (!arst_n)
    wd_expire && !(wr && wb_adr_i == `ADDR_WD_FEED)
    |=> sys_reset_req && wd_state_ff == WD_OFF)
    else $error("watchdog expiry without reset or disable");
  wd_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    sys_reset_req |-> wd_state_ff == WD_OFF)
    else $error("watchdog still enabled after its reset");
  wd_feed_a: assert property (@(posedge clk) disable iff (!arst_n)
    wd_state_ff == WD_RUN && wr && wb_adr_i == `ADDR_WD_FEED
    |=> wd_cnt_ff == $past(wd_load_ff) && !sys_reset_req)
    else $error("feed did not restore the watchdog count");
  wd_nmi_a: assert property (@(posedge clk) disable iff (!arst_n)
    wd_warn_ev |=> nmi)
    else $error("warning count did not raise the nmi");
  irq_mask_a: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 irq == |($past(status_ff[3:0]) & $past(mask_ff[3:0])))
    else $error("interrupt does not follow masked status");
  tout_a: assert property (@(posedge clk) disable iff (!arst_n)
    |hit |=> timer_out)
    else $error("timer event missing on shared output");
  // Checks the chained count itself, not just the tick routing.
  chain_a: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl_ff[`CTRL_CHAIN_BIT] && !hit[0] && !start[1]
    |=> count12[1] == $past(count12[1]))
    else $error("chained timer stepped without a timer 0 match");

  chain_c: cover property (@(posedge clk) disable iff (!arst_n)
    ctrl_ff[`CTRL_CHAIN_BIT] && hit[1]);
  wd_bite_c: cover property (@(posedge clk) disable iff (!arst_n)
    sys_reset_req);
  irq_c: cover property (@(posedge clk) disable iff (!arst_n) irq);
  nmi_c: cover property (@(posedge clk) disable iff (!arst_n) $rose(nmi));
endmodule : quad_timer

// [quad_timer_defines.svh]
// Constants for the quad timer and watchdog block.
// How it works
// - Two 12-bit timers run on the slow tick, each comparing its count against a match value.
// - Two 32-bit timers run on the system clock, each comparing its count against a match value.
// - Software configures all timers and the watchdog over the 32-bit register bus.
// - The 12-bit timers advance on the slow oscillator divided by two, 182.5 kHz.
// - The 32-bit timers advance once per system clock cycle.
// - Each timer has exactly one match register and no capture function.
// - Events of all four timers are merged onto one shared output line.
// - Timer 1 can be chained after timer 0; the 32-bit timers cannot chain.
// - Each timer can run single-shot or free-running.
// - Each timer raises a timeout interrupt that is masked on its own.
// - The watchdog is a 10-bit counter on the slow oscillator divided by 128.
// - The watchdog stays idle until software enables it.
// - An enabled watchdog that is not reloaded in time requests a system reset.
// - After a watchdog reset the watchdog is disabled.
// - The watchdog raises a non-maskable interrupt at a programmed count.
`ifndef QUAD_TIMER_DEFINES_SVH
`define QUAD_TIMER_DEFINES_SVH
`define CLK_HZ          25000000
`define SLOW_OSC_HZ     365000
`define T12_OSC_DIV     2
`define WD_OSC_DIV      128
`define T12_W           12
`define T32_W           32
`define WD_W            10
`define ADDR_CTRL       8'h00
`define ADDR_STATUS     8'h04
`define ADDR_MASK       8'h08
`define ADDR_WD_CTRL    8'h0C
`define ADDR_WD_LOAD    8'h10
`define ADDR_WD_FEED    8'h14
`define ADDR_WD_WARN    8'h18
`define ADDR_WD_COUNT   8'h1C
`define ADDR_MATCH0     8'h20
`define ADDR_COUNT0     8'h30
`define CTRL_RUN_LSB    0
`define CTRL_FREE_LSB   4
`define CTRL_CHAIN_BIT  8
`define ST_WD_BIT       4
`define WD_LOAD_RST     10'h3FF
`define WD_WARN_RST     10'h010
`endif

// [quad_timer_pkg.sv]
// Types shared by the quad timer and watchdog block.
package quad_timer_pkg;
  typedef enum logic [0:0] {
    WD_OFF = 1'b0,
    WD_RUN = 1'b1
  } wd_state_type;
endpackage : quad_timer_pkg

// [test_quad_timer_watchdog.sv]
// Self-checking bench for the quad timer and watchdog block.
`timescale 1ns/1ps
`include "quad_timer_defines.svh"
module test_quad_timer_watchdog;
  typedef struct {
    logic [7:0]  adr;
    logic        wr;
    logic [31:0] wdat;
    logic [31:0] exp;
  } row_type;

  logic        clk;
  logic        arst_n;
  logic        cyc, stb, we, ack, timer_out, irq, nmi, sys_reset_req;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  int          n_errors, n_tests, n_cyc, n_pulse, n_rst, p0, per;
  row_type     rows [11];

  cpu_bus_model bus (.clk(clk), .ack(ack), .rdat(rdat), .cyc(cyc),
    .stb(stb), .we(we), .adr(adr), .sel(sel), .wdat(wdat));

  // Short dividers keep the run brief; expectations follow from them.
  quad_timer #(.T12_DIV(2), .WD_DIV(4)) uut (.clk(clk), .arst_n(arst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .timer_out(timer_out), .irq(irq), .nmi(nmi),
    .sys_reset_req(sys_reset_req));

  initial clk = 1'b0;
  always #20 clk = ~clk;

  always @(posedge clk) begin
    n_cyc++;
    if (timer_out === 1'b1) n_pulse++;
    if (sys_reset_req === 1'b1) n_rst++;
    if (n_cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask : check

  task automatic expect_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus.read_word(a, q);
    check(q, e);
  endtask : expect_rd

  // Cycles between two successive pulses on the shared output line.
  task automatic period(output int n);
    while (timer_out !== 1'b1) @(posedge clk);
    @(posedge clk);
    n = 1;
    while (timer_out !== 1'b1) begin
      @(posedge clk);
      n++;
    end
  endtask : period

  initial begin
    rows = '{
      '{`ADDR_CTRL, 1'b0, 32'h0, 32'h0},
      '{`ADDR_STATUS, 1'b0, 32'h0, 32'h0},
      '{`ADDR_MASK, 1'b0, 32'h0, 32'h0},
      '{`ADDR_WD_CTRL, 1'b0, 32'h0, 32'h0},
      '{`ADDR_WD_LOAD, 1'b0, 32'h0, 32'h000003FF},
      '{`ADDR_WD_WARN, 1'b0, 32'h0, 32'h00000010},
      '{`ADDR_WD_COUNT, 1'b0, 32'h0, 32'h000003FF},
      '{8'h44, 1'b1, 32'hFFFFFFFF, 32'h0},
      '{`ADDR_MATCH0, 1'b1, 32'hFFFFFFFF, 32'h00000FFF},
      '{8'h2C, 1'b1, 32'hFFFFFFFF, 32'hFFFFFFFF},
      '{`ADDR_WD_LOAD, 1'b1, 32'hFFFFFFFF, 32'h000003FF}};
    arst_n = 1'b0;
    repeat (8) @(posedge clk);
    check({ack, timer_out, irq, nmi, sys_reset_req}, 32'h0);
    arst_n <= 1'b1;
    repeat (20) @(posedge clk);
    check(n_rst, 32'h0);
    check(nmi, 1'b0);
    for (int i = 0; i < 11; i++) begin
      if (rows[i].wr) bus.write_word(rows[i].adr, rows[i].wdat);
      expect_rd(rows[i].adr, rows[i].exp);
    end
    // Single-shot timer 2, interrupt enabled.
    bus.write_word(8'h28, 32'h5);
    bus.write_word(`ADDR_MASK, 32'h4);
    p0 = n_pulse;
    bus.write_word(`ADDR_CTRL, 32'h4);
    repeat (30) @(posedge clk);
    check(n_pulse - p0, 32'h1);
    expect_rd(8'h38, 32'h5);
    expect_rd(`ADDR_CTRL, 32'h0);
    expect_rd(`ADDR_STATUS, 32'h4);
    check(irq, 1'b1);
    bus.write_word(`ADDR_STATUS, 32'h4);
    repeat (3) @(posedge clk);
    check(irq, 1'b0);
    // Timer 3 fires while its own mask bit is clear.
    bus.write_word(8'h2C, 32'h3);
    bus.write_word(`ADDR_CTRL, 32'h8);
    repeat (20) @(posedge clk);
    expect_rd(`ADDR_STATUS, 32'h8);
    check(irq, 1'b0);
    bus.write_word(`ADDR_MASK, 32'hC);
    repeat (3) @(posedge clk);
    check(irq, 1'b1);
    bus.write_word(`ADDR_STATUS, 32'h8);
    // Free-running: counts 0..match, so a period is match plus one ticks.
    bus.write_word(8'h2C, 32'h9);
    bus.write_word(`ADDR_CTRL, 32'h88);
    period(per);
    check(per, 32'd10);
    bus.write_word(`ADDR_CTRL, 32'h0);
    bus.write_word(`ADDR_MATCH0, 32'h5);
    bus.write_word(`ADDR_CTRL, 32'h11);
    period(per);
    check(per, 32'd12);
    bus.write_word(`ADDR_CTRL, 32'h0);
    bus.write_word(`ADDR_STATUS, 32'h1F);
    expect_rd(`ADDR_STATUS, 32'h0);
    // Timer 1 chained behind a free-running timer 0.
    // Timer 0 needs eight slow ticks per match, so an unchained timer 1
    // would already have hit by the first read below.
    bus.write_word(`ADDR_MATCH0, 32'h7);
    bus.write_word(8'h24, 32'h2);
    bus.write_word(`ADDR_CTRL, 32'h113);
    repeat (8) @(posedge clk);
    expect_rd(`ADDR_STATUS, 32'h0);
    repeat (60) @(posedge clk);
    bus.write_word(`ADDR_CTRL, 32'h0);
    expect_rd(`ADDR_STATUS, 32'h3);
    bus.write_word(`ADDR_STATUS, 32'h1F);
    // Watchdog: feeding keeps it quiet, starving it ends in a reset.
    bus.write_word(`ADDR_WD_LOAD, 32'h3);
    bus.write_word(`ADDR_WD_WARN, 32'h1);
    bus.write_word(`ADDR_WD_CTRL, 32'h1);
    for (int i = 0; i < 20; i++) bus.write_word(`ADDR_WD_FEED, 32'h0);
    check(n_rst, 32'h0);
    check(nmi, 1'b0);
    for (int i = 0; i < 200 && n_rst == 0; i++) @(posedge clk);
    check(n_rst, 32'h1);
    check(nmi, 1'b1);
    expect_rd(`ADDR_WD_CTRL, 32'h0);
    expect_rd(`ADDR_STATUS, 32'h10);
    // A second reset in mid-run must bring back the idle defaults.
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    check({ack, timer_out, irq, nmi, sys_reset_req}, 32'h0);
    expect_rd(`ADDR_STATUS, 32'h0);
    expect_rd(`ADDR_MASK, 32'h0);
    expect_rd(`ADDR_WD_CTRL, 32'h0);
    expect_rd(`ADDR_WD_LOAD, 32'h000003FF);
    give_verdict();
  end
endmodule : test_quad_timer_watchdog

// [timer_chan.sv]
// One general purpose timer channel with a single match register.
`timescale 1ns/1ps
module timer_chan #(
  parameter int W = 12
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         tick,
  input  wire logic         start,
  input  wire logic         stop,
  input  wire logic         free_run,
  input  wire logic [W-1:0] match,
  output logic      [W-1:0] count_ff,
  output logic              hit_ff,
  output logic              running_ff
);
  logic at_match;
  assign at_match = (count_ff == match);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_ff <= '0;
    end else if (start) begin
      count_ff <= '0;
    end else if (running_ff && tick) begin
      if (at_match) begin
        count_ff <= free_run ? '0 : count_ff;
      end else begin
        count_ff <= count_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      running_ff <= 1'b0;
    end else if (start) begin
      running_ff <= 1'b1;
    end else if (stop) begin
      running_ff <= 1'b0;
    end else if (running_ff && tick && at_match && !free_run) begin
      running_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hit_ff <= 1'b0;
    end else begin
      hit_ff <= running_ff && tick && at_match && !start && !stop;
    end
  end

  single_shot_a: assert property (@(posedge clk) disable iff (!arst_n)
    running_ff && tick && at_match && !free_run && !start && !stop
    |=> !running_ff && hit_ff)
    else $error("single-shot timer kept running after match");
  free_wrap_a: assert property (@(posedge clk) disable iff (!arst_n)
    running_ff && tick && at_match && free_run && !start && !stop
    |=> running_ff && count_ff == '0 && hit_ff)
    else $error("free-running timer did not wrap on match");
endmodule : timer_chan
